// ---- pkg/lps_consts.vh ----
// constants for the parallel panel strobe timing block
`ifndef LPS_CONSTS_VH
`define LPS_CONSTS_VH

// register byte offsets
`define LPS_OFF_PRI_TIMING   8'h00
`define LPS_OFF_SEC_TIMING   8'h04
`define LPS_OFF_CTRL         8'h08
`define LPS_OFF_PRI_ADDR     8'h10
`define LPS_OFF_PRI_DATA     8'h14
`define LPS_OFF_SEC_ADDR     8'h18
`define LPS_OFF_SEC_DATA     8'h1c
`define LPS_OFF_STATUS       8'h20

// timing register fields
`define LPS_WSU_HI      31
`define LPS_WSU_LO      27
`define LPS_WSTB_HI     26
`define LPS_WSTB_LO     21
`define LPS_WHLD_HI     20
`define LPS_WHLD_LO     17
`define LPS_RSU_HI      16
`define LPS_RSU_LO      12
`define LPS_RSTB_HI     11
`define LPS_RSTB_LO     6
`define LPS_RHLD_HI     5
`define LPS_RHLD_LO     2
`define LPS_TA_HI       1
`define LPS_TA_LO       0

// control register fields
`define LPS_DIV_HI      15
`define LPS_DIV_LO      8
`define LPS_MODE_HI     2
`define LPS_MODE_LO     0

// reset values
`define LPS_TIMING_RST  32'h0022_0044
`define LPS_CTRL_RST    32'h0000_0103

// bus mode encodings
`define LPS_MODE_S68    3'h0
`define LPS_MODE_A68    3'h1
`define LPS_MODE_S80    3'h2
`define LPS_MODE_A80    3'h3
`define LPS_MODE_ENA    3'h4

`endif

// ---- rtl/lps_strobe_timing.v ----
// parallel panel port with per-select strobe timing and apb registers
`timescale 1ns/1ps
`include "lps_consts.vh"

module lps_strobe_timing (
   input  wire        core_clk,
   input  wire        reset,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [7:0]  paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output wire        pready,
   output wire        pslverr,
   output reg  [15:0] panel_data_out,
   output reg         panel_data_oe,
   input  wire [15:0] panel_data_in,
   output reg         panel_strobe_a,
   output reg         panel_strobe_b,
   output reg         panel_ale,
   output reg         panel_sel0,
   output reg         panel_sel1
);

   localparam [2:0] ST_IDLE  = 3'h0;
   localparam [2:0] ST_GAP   = 3'h1;
   localparam [2:0] ST_SETUP = 3'h2;
   localparam [2:0] ST_STB   = 3'h3;
   localparam [2:0] ST_HOLD  = 3'h4;
   localparam [2:0] ST_DONE  = 3'h5;

   reg [31:0] timing_q [0:1];
   reg [31:0] ctrl_q;
   reg [15:0] addr_reg_q [0:1];
   reg [15:0] data_reg_q [0:1];
   reg [2:0]  state_q;
   reg [5:0]  cnt_q;
   reg        sel_q;
   reg        rd_q;
   reg        adr_q;
   reg [7:0]  div_cnt_q;
   reg        tick_q;
   reg [1:0]  gap_q [0:1];
   reg [1:0]  last_rd_q;
   reg [15:0] sync1_q;
   reg [15:0] sync2_q;
   reg [15:0] sync3_q;
   reg [15:0] din_q;

   wire        setup_ph = (state_q == ST_SETUP);
   wire        apb_acc  = psel & penable;
   wire        hit_xfer = (paddr == `LPS_OFF_PRI_ADDR) | (paddr == `LPS_OFF_PRI_DATA) |
                          (paddr == `LPS_OFF_SEC_ADDR) | (paddr == `LPS_OFF_SEC_DATA);
   wire        hit_known = hit_xfer | (paddr == `LPS_OFF_PRI_TIMING) |
                           (paddr == `LPS_OFF_SEC_TIMING) | (paddr == `LPS_OFF_CTRL) |
                           (paddr == `LPS_OFF_STATUS);
   wire [31:0] cfg      = timing_q[sel_q];
   wire [2:0]  mode     = ctrl_q[`LPS_MODE_HI:`LPS_MODE_LO];
   wire [7:0]  div      = ctrl_q[`LPS_DIV_HI:`LPS_DIV_LO];
   wire        req_sel  = paddr[3];
   wire        req_adr  = ~paddr[2];
   // strobe pins follow the count: a zero width gives no strobe at all,
   // and the closing cycle of the strobe state already counts as hold
   wire        in_stb   = (state_q == ST_STB);
   wire        strobe   = in_stb & (cnt_q != 6'h00);
   wire        active   = setup_ph | in_stb | (state_q == ST_HOLD);
   // read word taken in the first cycle after the strobe window; the input
   // stages lag the pins, so a read strobe shorter than that lag reads stale
   wire        rd_take  = in_stb & (cnt_q == 6'h00) & rd_q;

   // transfers stall the bus until the panel access is complete
   assign pready  = hit_xfer ? (state_q == ST_DONE) : 1'b1;
   assign pslverr = apb_acc & ~hit_known;

   // memory-side clock enable, divider value 0 behaves as 1; the divider
   // runs free, so with a divider above one a phase may start mid-tick and
   // run up to one memory tick short of its count
   always @(posedge core_clk) begin
      if (reset) begin
         div_cnt_q <= 8'h00;
         tick_q    <= 1'b0;
      end else if (div_cnt_q + 8'h01 >= div || div == 8'h00) begin
         div_cnt_q <= 8'h00;
         tick_q    <= 1'b1;
      end else begin
         div_cnt_q <= div_cnt_q + 8'h01;
         tick_q    <= 1'b0;
      end
   end

   // panel data input: three stages, value taken when last two agree
   genvar b;
   generate
      for (b = 0; b < 16; b = b + 1) begin : g_sync
         always @(posedge core_clk) begin
            if (reset) begin
               sync1_q[b] <= 1'b0;
               sync2_q[b] <= 1'b0;
               sync3_q[b] <= 1'b0;
               din_q[b]   <= 1'b0;
            end else begin
               sync1_q[b] <= panel_data_in[b];
               sync2_q[b] <= sync1_q[b];
               sync3_q[b] <= sync2_q[b];
               if (sync2_q[b] == sync3_q[b]) begin
                  din_q[b] <= sync3_q[b];
               end
            end
         end
      end
   endgenerate

   // per-select turnaround counters, loaded when an access ends
   genvar s;
   generate
      for (s = 0; s < 2; s = s + 1) begin : g_gap
         always @(posedge core_clk) begin
            if (reset) begin
               gap_q[s]     <= 2'h0;
               last_rd_q[s] <= 1'b1;
            end else if (state_q == ST_HOLD && cnt_q == 6'h00 && sel_q == s) begin
               gap_q[s]     <= timing_q[s][`LPS_TA_HI:`LPS_TA_LO];
               last_rd_q[s] <= rd_q;
            end else if (tick_q && gap_q[s] != 2'h0) begin
               gap_q[s] <= gap_q[s] - 2'h1;
            end
         end
      end
   endgenerate

   // access sequencer: gap, setup, strobe, hold, then bus answer
   always @(posedge core_clk) begin
      if (reset) begin
         state_q <= ST_IDLE;
         cnt_q   <= 6'h00;
         sel_q   <= 1'b0;
         rd_q    <= 1'b1;
         adr_q   <= 1'b0;
      end else begin
         case (state_q)
            ST_IDLE: begin
               if (psel && !penable && hit_xfer) begin
                  sel_q   <= req_sel;
                  rd_q    <= ~pwrite;
                  adr_q   <= req_adr;
                  state_q <= ST_GAP;
               end
            end
            ST_GAP: begin
               // two reads in a row on one select skip the idle gap
               if ((rd_q && last_rd_q[sel_q]) || gap_q[sel_q] == 2'h0) begin
                  cnt_q   <= rd_q ? {1'b0, cfg[`LPS_RSU_HI:`LPS_RSU_LO]}
                                  : {1'b0, cfg[`LPS_WSU_HI:`LPS_WSU_LO]};
                  state_q <= ST_SETUP;
               end
            end
            ST_SETUP: begin
               // a zero setup count still costs one core cycle here
               if (cnt_q == 6'h00) begin
                  cnt_q   <= rd_q ? cfg[`LPS_RSTB_HI:`LPS_RSTB_LO]
                                  : cfg[`LPS_WSTB_HI:`LPS_WSTB_LO];
                  state_q <= ST_STB;
               end else if (tick_q) begin
                  cnt_q <= cnt_q - 6'h01;
               end
            end
            ST_STB: begin
               // the count-zero cycle closes the strobe and opens the hold
               if (cnt_q == 6'h00) begin
                  cnt_q   <= rd_q ? {2'b00, cfg[`LPS_RHLD_HI:`LPS_RHLD_LO]}
                                  : {2'b00, cfg[`LPS_WHLD_HI:`LPS_WHLD_LO]};
                  state_q <= ST_HOLD;
               end else if (tick_q) begin
                  cnt_q <= cnt_q - 6'h01;
               end
            end
            ST_HOLD: begin
               if (cnt_q == 6'h00) begin
                  state_q <= ST_DONE;
               end else if (tick_q) begin
                  cnt_q <= cnt_q - 6'h01;
               end
            end
            ST_DONE: begin
               state_q <= ST_IDLE;
            end
            default: begin
               state_q <= ST_IDLE;
            end
         endcase
      end
   end

   // configuration and access registers; read data lands at strobe end
   always @(posedge core_clk) begin
      if (reset) begin
         timing_q[0]   <= `LPS_TIMING_RST;
         timing_q[1]   <= `LPS_TIMING_RST;
         ctrl_q        <= `LPS_CTRL_RST;
         addr_reg_q[0] <= 16'h0000;
         addr_reg_q[1] <= 16'h0000;
         data_reg_q[0] <= 16'h0000;
         data_reg_q[1] <= 16'h0000;
      end else begin
         if (apb_acc && pwrite) begin
            case (paddr)
               `LPS_OFF_PRI_TIMING: timing_q[0] <= pwdata;
               `LPS_OFF_SEC_TIMING: timing_q[1] <= pwdata;
               `LPS_OFF_CTRL:       ctrl_q <= {16'h0000, pwdata[15:8], 5'h00, pwdata[2:0]};
               default: begin
               end
            endcase
         end
         // write data is latched at setup so it is stable on the pins
         if (psel && !penable && pwrite && state_q == ST_IDLE) begin
            if (paddr == `LPS_OFF_PRI_ADDR) addr_reg_q[0] <= pwdata[15:0];
            if (paddr == `LPS_OFF_SEC_ADDR) addr_reg_q[1] <= pwdata[15:0];
            if (paddr == `LPS_OFF_PRI_DATA) data_reg_q[0] <= pwdata[15:0];
            if (paddr == `LPS_OFF_SEC_DATA) data_reg_q[1] <= pwdata[15:0];
         end
         if (rd_take) begin
            if (adr_q) begin
               addr_reg_q[sel_q] <= din_q;
            end else begin
               data_reg_q[sel_q] <= din_q;
            end
         end
      end
   end

   // read mux; unmapped offsets read zero and flag an error
   always @* begin
      case (paddr)
         `LPS_OFF_PRI_TIMING: prdata = timing_q[0];
         `LPS_OFF_SEC_TIMING: prdata = timing_q[1];
         `LPS_OFF_CTRL:       prdata = ctrl_q;
         `LPS_OFF_PRI_ADDR:   prdata = {16'h0000, addr_reg_q[0]};
         `LPS_OFF_PRI_DATA:   prdata = {16'h0000, data_reg_q[0]};
         `LPS_OFF_SEC_ADDR:   prdata = {16'h0000, addr_reg_q[1]};
         `LPS_OFF_SEC_DATA:   prdata = {16'h0000, data_reg_q[1]};
         `LPS_OFF_STATUS:     prdata = {24'h000000, gap_q[1], gap_q[0], 1'b0, state_q};
         default:             prdata = 32'h0000_0000;
      endcase
   end

   // pin mapping per bus style; reserved modes behave as the 80 style
   always @(posedge core_clk) begin
      if (reset) begin
         panel_data_out <= 16'h0000;
         panel_data_oe  <= 1'b0;
         panel_strobe_a <= 1'b1;
         panel_strobe_b <= 1'b1;
         panel_ale      <= 1'b1;
         panel_sel0     <= 1'b1;
         panel_sel1     <= 1'b1;
      end else begin
         panel_data_out <= adr_q ? addr_reg_q[sel_q] : data_reg_q[sel_q];
         panel_data_oe  <= active & ~rd_q;
         panel_ale      <= ~(active & adr_q); // low marks an address cycle
         case (mode)
            `LPS_MODE_S68, `LPS_MODE_A68: begin
               panel_strobe_a <= strobe;          // high enable
               panel_strobe_b <= rd_q | ~active;  // read/write direction
               panel_sel0     <= ~(active & ~sel_q);
               panel_sel1     <= ~(active & sel_q);
            end
            `LPS_MODE_ENA: begin
               // enable style carries the strobe on the addressed select line only
               panel_strobe_a <= 1'b0;
               panel_strobe_b <= rd_q | ~active;
               panel_sel0     <= strobe & ~sel_q;
               panel_sel1     <= strobe & sel_q;
            end
            default: begin
               panel_strobe_a <= ~(strobe & rd_q);   // low read strobe
               panel_strobe_b <= ~(strobe & ~rd_q);  // low write strobe
               panel_sel0     <= ~(active & ~sel_q);
               panel_sel1     <= ~(active & sel_q);
            end
         endcase
      end
   end

endmodule

// ---- tb/lps_panel_model.sv ----
// behavioural panel module on the 80-style parallel bus
`timescale 1ns/1ps

module lps_panel_model (
   input  wire        core_clk,
   input  wire        panel_sel0,
   input  wire        panel_sel1,
   input  wire        panel_strobe_a,
   input  wire        panel_strobe_b,
   input  wire        panel_ale,
   input  wire [15:0] panel_data_out,
   output wire [15:0] panel_data_in,
   output reg         wr_ev,
   output reg         wr_sel,
   output reg         wr_ale,
   output reg  [15:0] wr_dat
);
   reg [15:0] mem0_q, mem1_q, last_q;
   reg        wb_q;
   wire       drv = !panel_strobe_a && !(panel_sel0 && panel_sel1);
   // drive only inside the read strobe; inverse of last word otherwise so stale data never matches
   assign panel_data_in = drv ? (panel_sel0 ? mem1_q : mem0_q) : ~last_q;
   // latch the word at the end of the write strobe, while hold keeps it valid
   always @(posedge core_clk) begin
      wr_ev <= 1'b0;
      if (drv) last_q <= panel_data_in;
      if (panel_strobe_b && !wb_q && !(panel_sel0 && panel_sel1)) begin
         wr_ev  <= 1'b1;
         wr_sel <= panel_sel0;
         wr_ale <= panel_ale;
         wr_dat <= panel_data_out;
         if (panel_ale && !panel_sel0) mem0_q <= panel_data_out;
         if (panel_ale && panel_sel0) mem1_q <= panel_data_out;
      end
      wb_q <= panel_strobe_b;
   end
endmodule

// ---- tb/lps_strobe_timing_assertions.sv ----
// pin timing checks for the panel port, 80-style modes only
`timescale 1ns/1ps
`include "lps_consts.vh"

module lps_strobe_timing_assertions (
   input wire        core_clk,
   input wire        reset,
   input wire        psel,
   input wire        penable,
   input wire        pwrite,
   input wire [7:0]  paddr,
   input wire [31:0] pwdata,
   input wire [31:0] prdata,
   input wire        pready,
   input wire        pslverr,
   input wire [15:0] panel_data_out,
   input wire        panel_data_oe,
   input wire [15:0] panel_data_in,
   input wire        panel_strobe_a,
   input wire        panel_strobe_b,
   input wire        panel_ale,
   input wire        panel_sel0,
   input wire        panel_sel1
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (reset);
   reg [2:0] mode_q;
   reg [7:0] div_q;
   reg [5:0] wstb_q, rstb_q;
   reg [6:0] wl_q, rl_q;
   reg [1:0] ok_q;
   wire wr  = psel && penable && pready && pwrite;
   wire wc  = wr && paddr == `LPS_OFF_CTRL;
   // pins settle a few edges after a mode change, so checks wait
   wire m80 = mode_q[2:1] == 2'b01 && ok_q == 2'h3;
   wire d1  = div_q <= 8'h01;
   // shadow of ctrl and primary timing, plus strobe-low counters
   always @(posedge core_clk) begin
      if (reset) begin
         mode_q <= 3'h3;
         div_q  <= 8'h01;
         wstb_q <= 6'h01;
         rstb_q <= 6'h01;
         ok_q   <= 2'h3;
      end else begin
         ok_q <= wc ? 2'h0 : (ok_q == 2'h3 ? ok_q : ok_q + 2'h1);
         if (wc) {div_q, mode_q} <= {pwdata[15:8], pwdata[2:0]};
         if (wr && paddr == `LPS_OFF_PRI_TIMING) {wstb_q, rstb_q} <= {pwdata[26:21], pwdata[11:6]};
      end
      wl_q <= panel_strobe_b ? 7'h0 : wl_q + 7'h1;
      rl_q <= panel_strobe_a ? 7'h0 : rl_q + 7'h1;
   end
   sequence s_wr_end; $rose(panel_strobe_b) && !panel_sel0; endsequence
   sequence s_rd_end; $rose(panel_strobe_a) && !panel_sel0; endsequence
   a_one_select: assert property (m80 |-> panel_sel0 || panel_sel1)
      else $error("both selects active");
   a_no_overlap: assert property (m80 |-> panel_strobe_a || panel_strobe_b)
      else $error("read and write strobes together");
   a_strobe_sel: assert property (m80 && !(panel_strobe_a && panel_strobe_b) |-> !(panel_sel0 && panel_sel1))
      else $error("strobe without select");
   a_wr_drives: assert property (m80 && !panel_strobe_b |-> panel_data_oe)
      else $error("write strobe without bus drive");
   a_setup_first: assert property (m80 && $fell(panel_strobe_b) |-> $past(panel_data_oe))
      else $error("write strobe before setup");
   a_wr_hold: assert property (m80 && $rose(panel_strobe_b) |-> panel_data_oe && !(panel_sel0 && panel_sel1))
      else $error("write hold dropped");
   a_rd_hold: assert property (m80 && $rose(panel_strobe_a) |-> !panel_data_oe && !(panel_sel0 && panel_sel1))
      else $error("read hold dropped");
   a_wr_width: assert property (m80 && d1 ##0 s_wr_end |-> wl_q == {1'b0, wstb_q})
      else $error("write strobe width wrong");
   a_rd_width: assert property (m80 && d1 ##0 s_rd_end |-> rl_q == {1'b0, rstb_q})
      else $error("read strobe width wrong");
endmodule

bind lps_strobe_timing lps_strobe_timing_assertions chk_u (.core_clk, .reset, .psel, .penable,
   .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .panel_data_out, .panel_data_oe,
   .panel_data_in, .panel_strobe_a, .panel_strobe_b, .panel_ale, .panel_sel0, .panel_sel1);

// ---- tb/tb_top.sv ----
// self-checking bench: apb master, panel model, result queues
`timescale 1ns/1ps
`include "lps_consts.vh"

module tb_top;
   reg         core_clk, reset, psel, penable, pwrite;
   reg  [7:0]  paddr;
   reg  [31:0] pwdata, t0, t1;
   reg  [15:0] d0, d1;
   wire [31:0] prdata;
   wire [15:0] panel_data_out, panel_data_in, wr_dat;
   wire        pready, pslverr, panel_data_oe, panel_strobe_a, panel_strobe_b;
   wire        panel_ale, panel_sel0, panel_sel1, wr_ev, wr_sel, wr_ale;
   integer     mismatches, total_checks, i;
   logic [31:0] rq[$], pq[$];
   lps_strobe_timing dut_u (.core_clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .panel_data_out, .panel_data_oe, .panel_data_in,
      .panel_strobe_a, .panel_strobe_b, .panel_ale, .panel_sel0, .panel_sel1);
   lps_panel_model pm_u (.core_clk, .panel_sel0, .panel_sel1, .panel_strobe_a, .panel_strobe_b,
      .panel_ale, .panel_data_out, .panel_data_in, .wr_ev, .wr_sel, .wr_ale, .wr_dat);
   initial begin
      core_clk = 0;
      forever #4 core_clk = ~core_clk;
   end
   task test_done;
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task cmp(input [31:0] g, input [31:0] e);
      total_checks++;
      if (g !== e) begin
         mismatches++;
         $display("MISMATCH %0t got %h exp %h", $time, g, e);
      end
   endtask
   task chk_rd(input [31:0] g, input [31:0] e); cmp(g, e); endtask
   task chk_pw(input [31:0] g, input [31:0] e); cmp(g, e); endtask
   // one apb transfer; waits for pready under a bound
   task apb(input w, input [7:0] a, input [31:0] d);
      integer n;
      {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
      @(posedge core_clk) penable <= 1'b1;
      n = 0;
      do begin
         @(posedge core_clk);
         n++;
      end while (pready !== 1'b1 && n < 3000);
      if (n >= 3000) begin
         mismatches++;
         test_done;
      end
      {psel, penable} <= 2'b00;
      @(posedge core_clk);
   endtask
   task rd(input [7:0] a, input [31:0] e); rq.push_back(e); apb(1'b0, a, 32'h0); endtask
   task pw(input [7:0] a, input [15:0] d, input s, input l);
      pq.push_back({14'h0, s, l, d});
      apb(1'b1, a, {16'h0, d});
   endtask
   // results taken off the queues as they show up at the outputs
   always @(posedge core_clk) begin
      if (psel && penable && pready === 1'b1 && !pwrite) chk_rd(prdata, rq.size() ? rq.pop_front() : 'x);
      if (wr_ev === 1'b1) chk_pw({14'h0, wr_sel, wr_ale, wr_dat}, pq.size() ? pq.pop_front() : 'x);
   end
   initial begin
      {mismatches, total_checks, psel, penable, pwrite, paddr, pwdata} = 0;
      reset = 1'b1;
      i = $urandom(32'h50c27dea);
      repeat (4) @(posedge core_clk);
      reset <= 1'b0;
      @(posedge core_clk);
      rd(`LPS_OFF_PRI_TIMING, `LPS_TIMING_RST);
      rd(`LPS_OFF_SEC_TIMING, `LPS_TIMING_RST);
      rd(`LPS_OFF_CTRL, `LPS_CTRL_RST);
      rd(8'h0c, 32'h0);
      for (i = 0; i < 5; i++) begin
         apb(1'b1, `LPS_OFF_CTRL, 32'h100 | i);
         rd(`LPS_OFF_CTRL, 32'h100 | i);
      end
      apb(1'b1, `LPS_OFF_CTRL, `LPS_CTRL_RST);
      // first pass zero setup, hold and gap on the primary select; then random counts
      for (i = 0; i < 8; i++) begin
         t0 = i ? $urandom | 32'h0020_0200 : 32'h0020_0200;
         t1 = $urandom | 32'h0020_0200;
         {d0, d1} = $urandom;
         apb(1'b1, `LPS_OFF_PRI_TIMING, t0);
         apb(1'b1, `LPS_OFF_SEC_TIMING, t1);
         rd(`LPS_OFF_PRI_TIMING, t0);
         pw(`LPS_OFF_PRI_ADDR, d1, 1'b0, 1'b0);
         pw(`LPS_OFF_PRI_DATA, d0, 1'b0, 1'b1);
         pw(`LPS_OFF_SEC_DATA, d1, 1'b1, 1'b1);
         rd(`LPS_OFF_PRI_DATA, {16'h0, d0});
         rd(`LPS_OFF_PRI_DATA, {16'h0, d0});
         rd(`LPS_OFF_SEC_DATA, {16'h0, d1});
      end
      apb(1'b1, `LPS_OFF_CTRL, 32'h0000_0203);
      pw(`LPS_OFF_PRI_DATA, d1, 1'b0, 1'b1);
      rd(`LPS_OFF_PRI_DATA, {16'h0, d1});
      test_done;
   end
endmodule
